/* rtl/bridge_pwm_consts.svh */
`ifndef BRIDGE_PWM_CONSTS_SVH
`define BRIDGE_PWM_CONSTS_SVH
`define ADDR_DUTY_UPPER 3'h0
`define ADDR_MODULE_CTRL 3'h1
`define ADDR_PERIOD_LIMIT 3'h2
`define ADDR_DEADBAND_CFG 3'h3
`define ADDR_DUTY_ACTIVE 3'h4
`define ADDR_TIMEBASE 3'h5
`define ADDR_TIMER_CTRL 3'h6
`define RST_DUTY_UPPER 8'h00
`define RST_MODULE_CTRL 8'h00
`define RST_PERIOD_LIMIT 8'hff
`define RST_DEADBAND_CFG 8'h00
`define RST_TIMER_CTRL 8'h00
`define CTRL_CFG_HI 7
`define CTRL_CFG_LO 6
`define CTRL_DIR_BIT 7
`define CTRL_DLOW_HI 5
`define CTRL_DLOW_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0
`define MODE_PWM_TOP 2'h3
`define POL_BD_BIT 0
`define POL_AC_BIT 1
`define DB_CNT_HI 6
`define TCTRL_ON_BIT 2
`define TCTRL_PS_HI 1
`define TCTRL_PS_LO 0
`define PS_DIV1 2'h0
`define PS_DIV4 2'h1
`define TOSC_NS 25
`define ICYC_TOSC 4
`define ICYC_CLKS (`ICYC_TOSC * `TOSC_NS / `TOSC_NS)
`define QPH_LAST 2'h3
`define PS4_LAST 2'h3
`define PS16_LAST 4'hf
`endif

/* rtl/bridge_pwm_pkg.sv */
package bridge_pwm_pkg;
  // One-hot output configuration, decoded from the two-bit field.
  typedef enum logic [3:0] {
    CFG_SINGLE = 4'b0001,
    CFG_FWD = 4'b0010,
    CFG_HALF = 4'b0100,
    CFG_REV = 4'b1000
  } out_cfg_e;
  typedef logic [9:0] duty_t;
endpackage

/* rtl/deadband_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module deadband_delay (
  input wire logic ref_clk, // Block clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic enable, // Delay path in use.
  input wire logic icyc_tick, // One pulse per instruction cycle.
  input wire logic [6:0] delay_cnt, // Dead-band length in instruction cycles.
  input wire logic raw_in, // Undelayed active-high drive.
  output logic delayed_out // Drive with its rise held back.
);
  logic [6:0] wait_ff;
  logic [6:0] nxt_wait;
  logic out_ff;
  logic nxt_out;

  // Falls pass at once; a rise waits until the count has elapsed, and a fall that
  // comes first restarts the wait, so a short active time never shows.
  always_comb begin
    nxt_wait = wait_ff;
    nxt_out = out_ff;
    if (!enable || !raw_in) begin
      nxt_wait = 7'h00;
      nxt_out = 1'b0;
    end else if (!out_ff) begin
      if (wait_ff >= delay_cnt) begin
        nxt_out = 1'b1;
      end else if (icyc_tick) begin
        nxt_wait = wait_ff + 7'h01;
      end
    end
  end

  // State registers.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_ff <= 7'h00;
      out_ff <= 1'b0;
    end else begin
      wait_ff <= nxt_wait;
      out_ff <= nxt_out;
    end
  end

  assign delayed_out = out_ff;

  // The output never rises while the wait is short of the count.
  property p_no_early_rise;
    @(posedge ref_clk) disable iff (srst)
      (!out_ff && wait_ff < delay_cnt) |=> !out_ff;
  endproperty
  a_no_early_rise: assert property (p_no_early_rise) else $error("dead-band rise too early");
endmodule // deadband_delay
`default_nettype wire

/* rtl/enhanced_bridge_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_pwm_consts.svh"
module enhanced_bridge_pwm (
  input wire logic ref_clk, // Oscillator clock, one period per Tosc.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [2:0] reg_addr, // Register index.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
  output logic pwm_out_a, // Bridge output A.
  output logic pwm_out_b, // Bridge output B.
  output logic pwm_out_c, // Bridge output C.
  output logic pwm_out_d // Bridge output D.
);
  // Software registers.
  logic [7:0] duty_upper_byte_ff, nxt_duty_upper_byte;
  logic [7:0] module_control_reg_ff, nxt_module_control_reg;
  logic [7:0] period_limit_reg_ff, nxt_period_limit_reg;
  logic [7:0] deadband_config_reg_ff, nxt_deadband_config_reg;
  logic [7:0] timer_ctrl_ff, nxt_timer_ctrl;
  logic [7:0] rdata_ff, nxt_rdata;
  // Timebase state.
  logic [1:0] qphase_ff, nxt_qphase;
  logic [3:0] pscnt_ff, nxt_pscnt;
  logic [7:0] timebase_count_ff, nxt_timebase_count;
  // Active, period-buffered state.
  bridge_pwm_pkg::duty_t duty_active_ff, nxt_duty_active;
  bridge_pwm_pkg::out_cfg_e cfg_act_ff, nxt_cfg_act;
  logic [1:0] pol_act_ff, nxt_pol_act;
  logic [6:0] db_act_ff, nxt_db_act;
  logic pwm_act_ff, nxt_pwm_act;
  logic mod_ff, nxt_mod;
  logic [3:0] logic_ff, nxt_logic;
  logic [3:0] pin_ff, nxt_pin;
  // Combinational helpers.
  logic pwm_sel, timer_on, icyc_tick, inc_tick, boundary, match, early_turn, fine_step;
  logic [1:0] sub2;
  bridge_pwm_pkg::duty_t duty_pend;
  bridge_pwm_pkg::out_cfg_e cfg_pend;
  logic db_a, db_b;

  // Two-bit configuration field to its one-hot mode.
  function automatic bridge_pwm_pkg::out_cfg_e decode_cfg(input logic [1:0] f);
    bridge_pwm_pkg::out_cfg_e r;
    case (f)
      2'h0: r = bridge_pwm_pkg::CFG_SINGLE;
      2'h1: r = bridge_pwm_pkg::CFG_FWD;
      2'h2: r = bridge_pwm_pkg::CFG_HALF;
      default: r = bridge_pwm_pkg::CFG_REV;
    endcase
    return r;
  endfunction

  // Decode of the written control fields.
  assign pwm_sel = module_control_reg_ff[`CTRL_MODE_HI:`CTRL_MODE_HI-1] == `MODE_PWM_TOP;
  assign cfg_pend = decode_cfg(module_control_reg_ff[`CTRL_CFG_HI:`CTRL_CFG_LO]);
  assign duty_pend = {duty_upper_byte_ff, module_control_reg_ff[`CTRL_DLOW_HI:`CTRL_DLOW_LO]};
  assign timer_on = timer_ctrl_ff[`TCTRL_ON_BIT];

  // Register writes; the active duty buffer is only writable outside pulse-width mode.
  always_comb begin
    nxt_duty_upper_byte = duty_upper_byte_ff;
    nxt_module_control_reg = module_control_reg_ff;
    nxt_period_limit_reg = period_limit_reg_ff;
    nxt_deadband_config_reg = deadband_config_reg_ff;
    nxt_timer_ctrl = timer_ctrl_ff;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_DUTY_UPPER: nxt_duty_upper_byte = reg_wdata;
        `ADDR_MODULE_CTRL: nxt_module_control_reg = reg_wdata;
        `ADDR_PERIOD_LIMIT: nxt_period_limit_reg = reg_wdata;
        `ADDR_DEADBAND_CFG: nxt_deadband_config_reg = reg_wdata;
        `ADDR_TIMER_CTRL: nxt_timer_ctrl = {5'h00, reg_wdata[2:0]};
        default: nxt_timer_ctrl = timer_ctrl_ff;
      endcase
    end
  end

  // Read mux; unmapped indices read zero, data stands one cycle after the strobe.
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_DUTY_UPPER: nxt_rdata = duty_upper_byte_ff;
        `ADDR_MODULE_CTRL: nxt_rdata = module_control_reg_ff;
        `ADDR_PERIOD_LIMIT: nxt_rdata = period_limit_reg_ff;
        `ADDR_DEADBAND_CFG: nxt_rdata = deadband_config_reg_ff;
        `ADDR_DUTY_ACTIVE: nxt_rdata = duty_active_ff[9:2];
        `ADDR_TIMEBASE: nxt_rdata = timebase_count_ff;
        `ADDR_TIMER_CTRL: nxt_rdata = timer_ctrl_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Instruction phase and prescaler; sub2 supplies the two fine bits of the compare.
  assign icyc_tick = qphase_ff == `QPH_LAST;
  always_comb begin
    nxt_qphase = qphase_ff + 2'h1;
    nxt_pscnt = pscnt_ff;
    case (timer_ctrl_ff[`TCTRL_PS_HI:`TCTRL_PS_LO])
      `PS_DIV1: begin
        inc_tick = icyc_tick;
        sub2 = qphase_ff;
      end
      `PS_DIV4: begin
        inc_tick = icyc_tick && pscnt_ff[1:0] == `PS4_LAST;
        sub2 = pscnt_ff[1:0];
      end
      default: begin
        inc_tick = icyc_tick && pscnt_ff == `PS16_LAST;
        sub2 = pscnt_ff[3:2];
      end
    endcase
    if (!timer_on) begin
      inc_tick = 1'b0;
    end else if (icyc_tick) begin
      nxt_pscnt = pscnt_ff + 4'h1;
    end
  end

  // Timebase counts increments and wraps on the period match.
  assign boundary = inc_tick && timebase_count_ff == period_limit_reg_ff;
  always_comb begin
    nxt_timebase_count = timebase_count_ff;
    if (boundary) begin
      nxt_timebase_count = 8'h00;
    end else if (inc_tick) begin
      nxt_timebase_count = timebase_count_ff + 8'h01;
    end
  end

  // Period-buffered copies; mode off drops the outputs at once.
  always_comb begin
    nxt_duty_active = duty_active_ff;
    nxt_cfg_act = cfg_act_ff;
    nxt_pol_act = pol_act_ff;
    nxt_db_act = db_act_ff;
    nxt_pwm_act = pwm_act_ff && pwm_sel;
    if (boundary && pwm_sel) begin
      nxt_duty_active = duty_pend;
      nxt_cfg_act = cfg_pend;
      nxt_pol_act = module_control_reg_ff[1:0];
      nxt_db_act = deadband_config_reg_ff[`DB_CNT_HI:0];
      nxt_pwm_act = 1'b1;
    end else if (!pwm_sel && reg_wr && reg_addr == `ADDR_DUTY_ACTIVE) begin
      nxt_duty_active = {reg_wdata, duty_active_ff[1:0]};
    end
  end

  // The fine count {timebase, sub2} steps on these clocks only.
  assign fine_step = timer_on && (timer_ctrl_ff[`TCTRL_PS_HI:`TCTRL_PS_LO] == `PS_DIV1
    || (icyc_tick && (timer_ctrl_ff[`TCTRL_PS_HI:`TCTRL_PS_LO] == `PS_DIV4
    || pscnt_ff[1:0] == `PS4_LAST)));

  // Modulated level: set at the boundary unless duty is zero, cleared on the fine match.
  // The match looks one step ahead, so the registered level is already low in the
  // step whose count equals the duty; otherwise every pulse would run one fine step long.
  // A duty beyond the period simply never finds its match.
  assign match = fine_step
    && duty_active_ff == {timebase_count_ff, sub2} + 10'h001;
  always_comb begin
    nxt_mod = mod_ff;
    if (!pwm_act_ff && !(boundary && pwm_sel)) begin
      nxt_mod = 1'b0;
    end else if (boundary) begin
      nxt_mod = duty_pend != 10'h000;
    end else if (match) begin
      nxt_mod = 1'b0;
    end
  end

  // Direction flips in the last increment before the new period.
  assign early_turn = pwm_act_ff && pwm_sel && timebase_count_ff == period_limit_reg_ff
    && (cfg_act_ff == bridge_pwm_pkg::CFG_FWD || cfg_act_ff == bridge_pwm_pkg::CFG_REV)
    && (cfg_pend == bridge_pwm_pkg::CFG_FWD || cfg_pend == bridge_pwm_pkg::CFG_REV)
    && cfg_pend != cfg_act_ff;

  // Half-bridge rise delays; the module sees the drive only in half-bridge.
  deadband_delay u_db_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(pwm_act_ff && cfg_act_ff == bridge_pwm_pkg::CFG_HALF),
    .icyc_tick(icyc_tick),
    .delay_cnt(db_act_ff),
    .raw_in(mod_ff),
    .delayed_out(db_a)
  );
  deadband_delay u_db_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(pwm_act_ff && cfg_act_ff == bridge_pwm_pkg::CFG_HALF),
    .icyc_tick(icyc_tick),
    .delay_cnt(db_act_ff),
    .raw_in(!mod_ff),
    .delayed_out(db_b)
  );

  // Active-high drive per output, bit 0 is A; then polarity per pin pair.
  always_comb begin
    nxt_logic = 4'h0;
    if (pwm_act_ff) begin
      case (cfg_act_ff)
        bridge_pwm_pkg::CFG_SINGLE: nxt_logic = {3'h0, mod_ff};
        bridge_pwm_pkg::CFG_HALF: nxt_logic = {2'h0, db_b, db_a};
        bridge_pwm_pkg::CFG_FWD: nxt_logic = {mod_ff, 2'h0, 1'b1};
        bridge_pwm_pkg::CFG_REV: nxt_logic = {2'h0, 1'b1, mod_ff} << 1;
        default: nxt_logic = 4'h0;
      endcase
      if (early_turn) begin
        nxt_logic = (cfg_pend == bridge_pwm_pkg::CFG_FWD) ? 4'h1 : 4'h4;
      end
    end
    nxt_pin = 4'h0;
    if (pwm_act_ff) begin
      nxt_pin[0] = nxt_logic[0] ^ pol_act_ff[`POL_AC_BIT];
      nxt_pin[2] = nxt_logic[2] ^ pol_act_ff[`POL_AC_BIT];
      nxt_pin[1] = nxt_logic[1] ^ pol_act_ff[`POL_BD_BIT];
      nxt_pin[3] = nxt_logic[3] ^ pol_act_ff[`POL_BD_BIT];
    end
  end

  // All state registers.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      duty_upper_byte_ff <= `RST_DUTY_UPPER;
      module_control_reg_ff <= `RST_MODULE_CTRL;
      period_limit_reg_ff <= `RST_PERIOD_LIMIT;
      deadband_config_reg_ff <= `RST_DEADBAND_CFG;
      timer_ctrl_ff <= `RST_TIMER_CTRL;
      rdata_ff <= 8'h00;
      qphase_ff <= 2'h0;
      pscnt_ff <= 4'h0;
      timebase_count_ff <= 8'h00;
      duty_active_ff <= 10'h000;
      cfg_act_ff <= bridge_pwm_pkg::CFG_SINGLE;
      pol_act_ff <= 2'h0;
      db_act_ff <= 7'h00;
      pwm_act_ff <= 1'b0;
      mod_ff <= 1'b0;
      logic_ff <= 4'h0;
      pin_ff <= 4'h0;
    end else begin
      duty_upper_byte_ff <= nxt_duty_upper_byte;
      module_control_reg_ff <= nxt_module_control_reg;
      period_limit_reg_ff <= nxt_period_limit_reg;
      deadband_config_reg_ff <= nxt_deadband_config_reg;
      timer_ctrl_ff <= nxt_timer_ctrl;
      rdata_ff <= nxt_rdata;
      qphase_ff <= nxt_qphase;
      pscnt_ff <= nxt_pscnt;
      timebase_count_ff <= nxt_timebase_count;
      duty_active_ff <= nxt_duty_active;
      cfg_act_ff <= nxt_cfg_act;
      pol_act_ff <= nxt_pol_act;
      db_act_ff <= nxt_db_act;
      pwm_act_ff <= nxt_pwm_act;
      mod_ff <= nxt_mod;
      logic_ff <= nxt_logic;
      pin_ff <= nxt_pin;
    end
  end

  assign reg_rdata = rdata_ff;
  assign pwm_out_a = pin_ff[0];
  assign pwm_out_b = pin_ff[1];
  assign pwm_out_c = pin_ff[2];
  assign pwm_out_d = pin_ff[3];

  // Checks on the timing and output relations.
  sequence s_boundary_load;
    boundary && pwm_sel ##1 1'b1;
  endsequence
  property p_duty_load;
    @(posedge ref_clk) disable iff (srst)
      s_boundary_load |-> duty_active_ff == $past(duty_pend);
  endproperty
  a_duty_load: assert property (p_duty_load) else $error("duty not loaded at boundary");

  property p_duty_ro;
    @(posedge ref_clk) disable iff (srst)
      (pwm_sel && !boundary) |=> $stable(duty_active_ff);
  endproperty
  a_duty_ro: assert property (p_duty_ro) else $error("active duty changed mid period");

  property p_clear_on_match;
    @(posedge ref_clk) disable iff (srst)
      (pwm_act_ff && match && !boundary) |=> !mod_ff;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("output not cleared");

  property p_overlong_duty;
    @(posedge ref_clk) disable iff (srst)
      (pwm_act_ff && pwm_sel && mod_ff && !reg_wr && !boundary
       && duty_active_ff > {period_limit_reg_ff, 2'h3}) |=> mod_ff;
  endproperty
  a_overlong_duty: assert property (p_overlong_duty) else $error("overlong duty cleared");

  property p_period_start;
    @(posedge ref_clk) disable iff (srst)
      (boundary && pwm_sel && duty_pend != 10'h000) |=> mod_ff && timebase_count_ff == 8'h00;
  endproperty
  a_period_start: assert property (p_period_start) else $error("period start wrong");

  property p_tick_spacing;
    @(posedge ref_clk) disable iff (srst)
      inc_tick |=> !inc_tick [*3];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("increment too soon");

  property p_two_active;
    @(posedge ref_clk) disable iff (srst)
      (cfg_act_ff == bridge_pwm_pkg::CFG_FWD || cfg_act_ff == bridge_pwm_pkg::CFG_REV)
      |-> $countones(logic_ff) <= 2;
  endproperty
  a_two_active: assert property (p_two_active) else $error("too many outputs active");

  property p_forward;
    @(posedge ref_clk) disable iff (srst)
      (pwm_act_ff && cfg_act_ff == bridge_pwm_pkg::CFG_FWD && !early_turn)
      |=> logic_ff[0] && !logic_ff[1] && !logic_ff[2] && logic_ff[3] == $past(mod_ff);
  endproperty
  a_forward: assert property (p_forward) else $error("forward drive wrong");

  property p_reverse;
    @(posedge ref_clk) disable iff (srst)
      (pwm_act_ff && cfg_act_ff == bridge_pwm_pkg::CFG_REV && !early_turn)
      |=> logic_ff[2] && !logic_ff[0] && !logic_ff[3] && logic_ff[1] == $past(mod_ff);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse drive wrong");

  property p_early_turn;
    @(posedge ref_clk) disable iff (srst)
      early_turn |=> !logic_ff[1] && !logic_ff[3] && (logic_ff[0] != logic_ff[2]);
  endproperty
  a_early_turn: assert property (p_early_turn) else $error("direction turn wrong");

  property p_half_off;
    @(posedge ref_clk) disable iff (srst)
      (pwm_act_ff && cfg_act_ff == bridge_pwm_pkg::CFG_HALF && !mod_ff) ##1 !mod_ff |=> !logic_ff[0];
  endproperty
  a_half_off: assert property (p_half_off) else $error("half-bridge A not off");

  property p_idle;
    @(posedge ref_clk) disable iff (srst)
      !pwm_act_ff |=> pin_ff == 4'h0 || $past(boundary);
  endproperty
  a_idle: assert property (p_idle) else $error("output active while idle");
endmodule // enhanced_bridge_pwm
`default_nettype wire

/* testbench/bridge_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bridge_switch_model #(
  parameter int TOFF = 2
) (
  input wire logic ref_clk, // Block clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [3:0] pins, // Gate pins, D down to A.
  input wire logic [3:0] pin_is_out, // Port direction per pin, 1 is output.
  input wire logic [1:0] pol_low, // Active-low pairs: bit 1 A/C, bit 0 B/D.
  output int shoot // Cycles with both switches of one leg conducting.
);
  logic [3:0] gate;
  logic [3:0] sw_on;
  int off_cnt [4];
  // A pin left as input is pulled to the driver's off level.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = pin_is_out[i] & (pins[i] ^ pol_low[i % 2 == 0]);
      sw_on[i] = gate[i] | (off_cnt[i] > 0);
    end
  end
  // Switches turn off TOFF cycles late, so a leg can conduct through both sides.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shoot <= 0;
      off_cnt <= '{0, 0, 0, 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        off_cnt[i] <= gate[i] ? TOFF : (off_cnt[i] > 0 ? off_cnt[i] - 1 : 0);
      end
      shoot <= shoot + int'((sw_on[0] & sw_on[1]) | (sw_on[2] & sw_on[3]));
    end
  end
endmodule // bridge_switch_model
`default_nettype wire

/* testbench/enhanced_bridge_pwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_pwm_consts.svh"
module enhanced_bridge_pwm_tb;
  localparam int LIMIT = 60000;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] pin_is_out = 4'h0;
  logic [1:0] pol_low = 2'h0;
  logic [31:0] seed = 32'h00013f52;
  wire [3:0] pins;
  wire [3:0] act_now = pins ^ {pol_low[0], pol_low[1], pol_low[0], pol_low[1]};
  int shoot;
  int s0;
  int n;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  enhanced_bridge_pwm i_enhanced_bridge_pwm (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_out_a(pins[0]), .pwm_out_b(pins[1]),
    .pwm_out_c(pins[2]), .pwm_out_d(pins[3]));
  bridge_switch_model i_bridge_switch_model (.ref_clk(ref_clk), .srst(srst), .pins(pins),
    .pin_is_out(pin_is_out), .pol_low(pol_low), .shoot(shoot));

  // Clock at 40 MHz.
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // A hang is cut short after a fixed budget of cycles.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol,
      input string what);
    logic ok;
    ok = (got + tol >= exp) && (got <= exp + tol);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int psv(int ps);
    return ps == 0 ? 1 : (ps == 1 ? 4 : 16);
  endfunction

  // Active cycles per period window; a pin held active has no new rise.
  function automatic int exp_act(int cfg, int i, int h, int t, int db);
    int a;
    int b;
    a = h == t ? t : (h - 4 * db < 0 ? 0 : h - 4 * db);
    b = h == 0 ? t : (t - h - 4 * db < 0 ? 0 : t - h - 4 * db);
    case (cfg)
      0: return i == 0 ? h : 0;
      1: return i == 0 ? t : (i == 3 ? h : 0);
      2: return i == 0 ? a : (i == 1 ? b : 0);
      default: return i == 2 ? t : (i == 1 ? h : 0);
    endcase
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e}, 0, "read data");
  endtask

  // Fresh reset per case, so a shorter period never waits out a timebase wrap.
  task automatic start(input int cfg, input int pol, input int ps, input int per,
      input int duty, input int db);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    pol_low <= pol[1:0];
    pin_is_out <= cfg == 0 ? 4'h1 : (cfg == 2 ? 4'h3 : 4'hf);
    wr(`ADDR_DUTY_UPPER, duty[9:2]);
    wr(`ADDR_DEADBAND_CFG, db[7:0]);
    wr(`ADDR_PERIOD_LIMIT, per[7:0]);
    wr(`ADDR_MODULE_CTRL, {cfg[1:0], duty[1:0], 2'b11, pol[1:0]});
    wr(`ADDR_TIMER_CTRL, {5'h00, 1'b1, ps[1:0]});
    repeat (8 * (per + 1) * psv(ps) + 16) @(posedge ref_clk);
  endtask

  // Any window one period long holds the same active time and at most one rise.
  task automatic measure(input int cfg, input int ps, input int per, input int duty,
      input int db);
    int t;
    int h;
    int e;
    int r;
    int tol;
    int act [4];
    int rise [4];
    logic [3:0] prev;
    t = 4 * (per + 1) * psv(ps);
    h = duty * psv(ps) > t ? t : duty * psv(ps);
    act = '{0, 0, 0, 0};
    rise = '{0, 0, 0, 0};
    s0 = shoot;
    #1;
    prev = act_now;
    for (int k = 0; k < t; k++) begin
      @(posedge ref_clk);
      #1;
      chk(16'($countones(act_now) > 2), 16'h0000, 0, "too many active");
      for (int i = 0; i < 4; i++) begin
        act[i] += act_now[i];
        rise[i] += act_now[i] & ~prev[i];
      end
      prev = act_now;
    end
    for (int i = 0; i < 4; i++) begin
      e = exp_act(cfg, i, h, t, db);
      r = i == 0 ? h : t - h;
      tol = (cfg == 2 && db > 0 && r - 4 * db > -4) ? 4 : 0;
      chk(16'(act[i]), 16'(e), tol, "active time");
      chk(16'(rise[i]), 16'(e > 0 && e < t), tol > 0, "rises");
    end
    if (!(cfg == 2 && db == 0)) begin
      chk(16'(shoot - s0), 16'h0000, 0, "shoot-through");
    end
  endtask

  task automatic run_case(input int cfg, input int pol, input int ps, input int per,
      input int duty, input int db);
    start(cfg, pol, ps, per, duty, db);
    measure(cfg, ps, per, duty, db);
  endtask

  // Main sequence: reset values, buffering, corners, direction change, random cases.
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), a == 2 ? `RST_PERIOD_LIMIT : 8'h00);
    wr(`ADDR_MODULE_CTRL, 8'h0f);
    wr(`ADDR_DUTY_ACTIVE, 8'h5a);
    wr(`ADDR_DUTY_UPPER, 8'h33);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      chk({12'h000, pins}, 16'h0000, 0, "idle pins");
    end
    rd(`ADDR_DUTY_ACTIVE, 8'h00);
    rd(`ADDR_DUTY_UPPER, 8'h33);
    wr(`ADDR_PERIOD_LIMIT, 8'h03);
    wr(`ADDR_TIMER_CTRL, 8'h04);
    repeat (40) @(posedge ref_clk);
    rd(`ADDR_DUTY_ACTIVE, 8'h33);
    wr(`ADDR_DUTY_ACTIVE, 8'h00);
    rd(`ADDR_DUTY_ACTIVE, 8'h33);
    run_case(0, 0, 0, 3, 7, 3);
    run_case(0, 1, 1, 3, 0, 0);
    run_case(0, 0, 2, 1, 9, 0);
    for (int p = 0; p < 4; p++) run_case(1, p, 1, 2, 5, 2);
    run_case(3, 3, 0, 5, 11, 1);
    run_case(2, 0, 0, 7, 20, 2);
    run_case(2, 2, 0, 7, 20, 6);
    start(1, 0, 0, 7, 30, 0);
    wr(`ADDR_DUTY_UPPER, 8'h01);
    repeat (80) @(posedge ref_clk);
    s0 = shoot;
    repeat (rnd() % 32) @(posedge ref_clk);
    wr(`ADDR_MODULE_CTRL, 8'hcc);
    for (n = 1; n < 64; n++) begin
      @(posedge ref_clk);
      #1;
      if (pins[2] === 1'b1) break;
      chk({15'h0000, pins[0]}, 16'h0001, 0, "old direction");
    end
    chk(16'(n <= 40), 16'h0001, 0, "direction late");
    chk({12'h000, pins}, 16'h0004, 0, "switch state");
    repeat (2) @(posedge ref_clk);
    #1;
    chk({15'h0000, pins[1]}, 16'h0000, 0, "early modulation");
    chk(16'(shoot - s0), 16'h0000, 0, "reversal shoot-through");
    repeat (40) @(posedge ref_clk);
    measure(3, 0, 7, 4, 0);
    for (int k = 0; k < 6; k++) begin
      n = 1 + rnd() % 15;
      run_case(rnd() % 4, rnd() % 4, rnd() % 4, n, rnd() % (4 * n + 8), rnd() % 8);
    end
    end_sim();
  end
endmodule // enhanced_bridge_pwm_tb
`default_nettype wire
